/* File: core/freq_switch_pkg.sv */
// shared constants and types for the frequency window switch
package freq_switch_pkg;

  // ------------------------------------------------------------------
  // axi4-lite register byte offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] UPPER_OFS  = 8'h04;
  localparam logic [7:0] LOWER_OFS  = 8'h08;
  localparam logic [7:0] FAIL_OFS   = 8'h0C;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  localparam logic [7:0] PERIOD_OFS = 8'h14;

  // ------------------------------------------------------------------
  // control register fields
  // ------------------------------------------------------------------
  localparam int CTRL_LATCH_A_BIT = 0;
  localparam int CTRL_LATCH_B_BIT = 1;
  localparam int CTRL_INVERT_BIT  = 2;
  localparam int CTRL_FAILEN_BIT  = 3;
  localparam int CTRL_SLATCH_BIT  = 4;
  localparam int CTRL_SMODE_LSB   = 5;
  localparam int CTRL_SMODE_W     = 2;
  // every control bit reads as one after reset, like an open pin
  localparam logic [6:0] CTRL_RESET = 7'h7F;

  // ------------------------------------------------------------------
  // reset values and timing counts
  // ------------------------------------------------------------------
  localparam int          CNT_W        = 24;
  localparam logic [23:0] UPPER_RESET  = 24'h000FA0;
  localparam logic [23:0] LOWER_RESET  = 24'h001F40;
  localparam logic [23:0] FAIL_RESET   = 24'h013880;
  localparam int          CONFIRM_CYC  = 10;   // zero-crossings to confirm after the first
  localparam logic [3:0]  CONFIRM_LAST = 4'(CONFIRM_CYC - 1);

  // single-variant mode selector encoding (defaults for MODE_UPPER, MODE_LOWER, MODE_HYST)
  localparam logic [1:0] SMODE_UPPER = 2'h0;
  localparam logic [1:0] SMODE_LOWER = 2'h1;
  localparam logic [1:0] SMODE_HYST  = 2'h3;

  // band classification of one period sample
  typedef enum logic [1:0] {
    BAND_BELOW = 2'b00,
    BAND_IN    = 2'b01,
    BAND_ABOVE = 2'b11
  } band_e;

endpackage

/* File: core/period_sampler.sv */
// period measurement between input zero-crossings
`timescale 1ns/1ps
module period_sampler
  import freq_switch_pkg::*;
#(
  parameter int W = CNT_W
) (
  input  wire logic         clk_i,
  input  wire logic         arst_n_i,
  input  wire logic         sig_i,
  output logic              sample_o,
  output logic [W-1:0]      period_o,
  output logic              stall_o
);

  typedef struct packed {
    logic         s1;
    logic         s2;
    logic         s3;
    logic [W-1:0] cnt;
    logic         sample;
    logic [W-1:0] period;
    logic         stall;
  } state_s;

  state_s q;
  state_s d;

  // ------------------------------------------------------------------
  // sync, edge detect, interval count
  // ------------------------------------------------------------------
  // every edge of the shaped input is one zero-crossing
  always_comb begin
    d        = q;
    d.s1     = sig_i;
    d.s2     = q.s1;
    d.s3     = q.s2;
    d.sample = 1'b0;
    if (q.s2 != q.s3) begin
      d.period = q.cnt;
      d.sample = 1'b1;
      d.cnt    = W'(1);
      d.stall  = 1'b0;
    end else if (q.cnt != {W{1'b1}}) begin
      d.cnt = q.cnt + W'(1);
    end else begin
      d.stall = 1'b1;  // saturated: no input at all
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= '0;
      q.stall <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign sample_o = q.sample;
  assign period_o = q.period;
  assign stall_o  = q.stall;

endmodule

/* File: core/freq_window_switch.sv */
// frequency window switch: dual and single variants behind axi4-lite
// How it works
// - period is time between input zero-crossings
// - compare period, confirm by noise-rejecting counter
// - harmonic samples gated from the counter
// - below-band on with no or low input
// - reaching lower point: in-band on, below off
// - passing upper point: above on, in-band off
// - exactly one dual output active
// - both latch controls zero: unlatched
// - both one: latch above or below
// - first one only: latch above band
// - second one only: latch below band
// - latch clears on normal input, controls zero
// - inversion flips all three dual outputs
// - controls read one unless driven
// - lower at or below upper: no in-band state
// - single outputs complementary, off when low
// - mode selector picks upper, lower, hysteresis
// - upper datum: on at and above upper
// - lower datum: on at and above lower
// - hysteresis: on upper, off at lower
// - single latch control latches output low
// - response takes eleven zero-crossings
// - failure control zero ignores interruptions
// - failure control one forces low quickly
//
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module freq_window_switch
  import freq_switch_pkg::*;
#(
  parameter logic [1:0] MODE_UPPER = SMODE_UPPER,
  parameter logic [1:0] MODE_LOWER = SMODE_LOWER,
  parameter logic [1:0] MODE_HYST  = SMODE_HYST
) (
  input  wire logic        CLK_SYS_I,
  input  wire logic        ARST_N_I,
  input  wire logic        SIG_I,
  output logic             BELOW_BAND_O,
  output logic             IN_BAND_O,
  output logic             ABOVE_BAND_O,
  output logic             SW_OUT1_O,
  output logic             SW_OUT2_O,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  output logic [1:0]       S_AXI_BRESP,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP
);

  typedef struct packed {
    // bus slave
    logic             aw_got;
    logic [7:0]       aw_addr;
    logic             w_got;
    logic [31:0]      w_data;
    logic [3:0]       w_strb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
    // configuration
    logic [6:0]       ctrl;
    logic [CNT_W-1:0] upper;
    logic [CNT_W-1:0] lower;
    logic [CNT_W-1:0] fail;
    // confirmation
    band_e            cand;
    logic [3:0]       conf;
    band_e            band;
    logic [CNT_W-1:0] last_p;
    logic             hyst_on;
    // latches
    logic             lat_above;
    logic             lat_below;
    logic             slat;
    logic             slat_armed;
    // failure timer
    logic [CNT_W-1:0] idle;
    // outputs
    logic             o_below;
    logic             o_in;
    logic             o_above;
    logic             o_s1;
    logic             o_s2;
  } state_s;

  state_s q;
  state_s d;

  logic             smp;
  logic [CNT_W-1:0] per;
  logic             stalled;

  // ------------------------------------------------------------------
  // period measurement
  // ------------------------------------------------------------------
  period_sampler #(
    .W (CNT_W)
  ) u_sampler (
    .clk_i    (CLK_SYS_I),
    .arst_n_i (ARST_N_I),
    .sig_i    (SIG_I),
    .sample_o (smp),
    .period_o (per),
    .stall_o  (stalled)
  );

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    logic       wr;
    logic       rd;
    logic       la;
    logic       lb;
    logic       fail_en;
    logic       failed;
    logic       harm;
    logic       s_on;
    logic       wide;
    band_e      sb;
    band_e      live;
    wr      = 1'b0;
    rd      = 1'b0;
    la      = 1'b0;
    lb      = 1'b0;
    fail_en = 1'b0;
    failed  = 1'b0;
    harm    = 1'b0;
    s_on    = 1'b0;
    wide    = 1'b0;
    sb      = BAND_BELOW;
    live    = BAND_BELOW;
    d       = q;

    // write channel: address and data taken in either order
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      d.aw_got  = 1'b1;
      d.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      d.w_got  = 1'b1;
      d.w_data = S_AXI_WDATA;
      d.w_strb = S_AXI_WSTRB;
    end
    if (q.bvalid && S_AXI_BREADY) begin
      d.bvalid = 1'b0;
    end
    wr = q.aw_got && q.w_got && !q.bvalid;
    if (wr) begin
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = 2'b00;
      // low three bytes only, control low byte only; the other byte lanes are ignored
      unique case (q.aw_addr)
        CTRL_OFS:  if (q.w_strb[0]) d.ctrl = q.w_data[6:0];
        UPPER_OFS: for (int i = 0; i < 3; i++) begin
          if (q.w_strb[i]) d.upper[i*8 +: 8] = q.w_data[i*8 +: 8];
        end
        LOWER_OFS: for (int i = 0; i < 3; i++) begin
          if (q.w_strb[i]) d.lower[i*8 +: 8] = q.w_data[i*8 +: 8];
        end
        FAIL_OFS:  for (int i = 0; i < 3; i++) begin
          if (q.w_strb[i]) d.fail[i*8 +: 8] = q.w_data[i*8 +: 8];
        end
        STATUS_OFS, PERIOD_OFS: d.bresp = 2'b10;  // read-only
        default:   d.bresp = 2'b10;
      endcase
    end

    // read channel: one cycle to answer
    if (q.rvalid && S_AXI_RREADY) begin
      d.rvalid = 1'b0;
    end
    rd = S_AXI_ARVALID && S_AXI_ARREADY;
    if (rd) begin
      d.rvalid = 1'b1;
      d.rresp  = 2'b00;
      unique case (S_AXI_ARADDR)
        CTRL_OFS:   d.rdata = {25'h0000000, q.ctrl};
        UPPER_OFS:  d.rdata = {8'h00, q.upper};
        LOWER_OFS:  d.rdata = {8'h00, q.lower};
        FAIL_OFS:   d.rdata = {8'h00, q.fail};
        STATUS_OFS: d.rdata = {20'h00000, q.slat, q.lat_below, q.lat_above,
                               q.conf, q.o_s1, q.band, q.o_above, q.o_in};
        PERIOD_OFS: d.rdata = {8'h00, q.last_p};
        default: begin
          d.rdata = 32'h00000000;
          d.rresp = 2'b10;
        end
      endcase
    end

    la      = q.ctrl[CTRL_LATCH_A_BIT];
    lb      = q.ctrl[CTRL_LATCH_B_BIT];
    fail_en = q.ctrl[CTRL_FAILEN_BIT];

    // classify a sample: longer period means lower frequency
    if (smp) begin
      d.last_p = per;
      if (per <= q.upper) begin
        sb = BAND_ABOVE;
      end else if (per <= q.lower && q.lower > q.upper) begin
        sb = BAND_IN;
      end else begin
        sb = BAND_BELOW;
      end
      // a sample at or below half the previous, in a new band, is a harmonic artefact
      harm = (q.last_p != '0) && ({per, 1'b0} <= {1'b0, q.last_p}) &&
             (sb != q.band) && (sb != q.cand);
      if (!harm) begin
        if (sb == q.cand) begin
          if (q.conf != CONFIRM_LAST) begin
            d.conf = q.conf + 4'h1;
          end else begin
            d.band = sb;
          end
        end else begin
          d.cand = sb;
          d.conf = 4'h0;
        end
      end
    end

    // failure timer: run on a stalled input
    if (smp) begin
      d.idle = '0;
    end else if (q.idle != {CNT_W{1'b1}}) begin
      d.idle = q.idle + CNT_W'(1);
    end
    wide   = stalled || (q.idle >= q.fail);
    failed = fail_en && wide;
    if (failed || stalled) begin
      d.band = BAND_BELOW;
      d.cand = BAND_BELOW;
      d.conf = 4'h0;
    end
    // with failure off, only confirmed bands and a stalled sampler move outputs

    // dual latches
    live = d.band;
    if (!la && !lb) begin
      if (live != BAND_ABOVE) d.lat_above = 1'b0;
      if (live != BAND_BELOW) d.lat_below = 1'b0;
    end
    if (la && live == BAND_ABOVE) d.lat_above = 1'b1;
    if (lb && live == BAND_BELOW) d.lat_below = 1'b1;
    if (d.lat_above) begin
      live = BAND_ABOVE;
    end else if (d.lat_below) begin
      live = BAND_BELOW;
    end
    // one-hot by construction; one-cold when the invert bit is set
    d.o_below = (live == BAND_BELOW) ^ q.ctrl[CTRL_INVERT_BIT];
    d.o_in    = (live == BAND_IN) ^ q.ctrl[CTRL_INVERT_BIT];
    d.o_above = (live == BAND_ABOVE) ^ q.ctrl[CTRL_INVERT_BIT];

    // single variant: reuse the same confirmed band
    if (d.band == BAND_ABOVE) begin
      d.hyst_on = 1'b1;
    end else if (d.band == BAND_BELOW) begin
      d.hyst_on = 1'b0;
    end
    unique case (q.ctrl[CTRL_SMODE_LSB +: CTRL_SMODE_W])
      MODE_UPPER: s_on = (d.band == BAND_ABOVE);
      MODE_LOWER: s_on = (d.band != BAND_BELOW)
                         || (q.lower <= q.upper && d.band == BAND_ABOVE);
      MODE_HYST:  s_on = d.hyst_on;
      default:    s_on = (d.band == BAND_ABOVE);
    endcase
    // lower datum: a sample inside lower keeps a high output; with inverted points the band switches it at upper
    if (q.ctrl[CTRL_SMODE_LSB +: CTRL_SMODE_W] == MODE_LOWER && smp) begin
      s_on = (per <= q.lower) ? q.o_s1 | (d.band != BAND_BELOW) : s_on;
    end
    // latch low until high input and control zero
    if (!q.ctrl[CTRL_SLATCH_BIT]) begin
      if (s_on) d.slat = 1'b0;
      d.slat_armed = 1'b0;
    end else if (!s_on) begin
      d.slat = 1'b1;
    end
    d.o_s1 = s_on && !d.slat;
    d.o_s2 = !d.o_s1;

    if (failed) begin
      d.o_s1 = 1'b0;
      d.o_s2 = 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      q         <= '0;
      q.ctrl    <= CTRL_RESET;
      q.upper   <= UPPER_RESET;
      q.lower   <= LOWER_RESET;
      q.fail    <= FAIL_RESET;
      q.slat    <= 1'b1;
      q.o_below <= 1'b0;  // inverted by default control
      q.o_in    <= 1'b1;
      q.o_above <= 1'b1;  // only below is active, as after release
      q.o_s2    <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign BELOW_BAND_O  = q.o_below;
  assign IN_BAND_O     = q.o_in;
  assign ABOVE_BAND_O  = q.o_above;
  assign SW_OUT1_O     = q.o_s1;
  assign SW_OUT2_O     = q.o_s2;
  assign S_AXI_AWREADY = !q.aw_got;
  assign S_AXI_WREADY  = !q.w_got;
  assign S_AXI_BVALID  = q.bvalid;
  assign S_AXI_BRESP   = q.bresp;
  assign S_AXI_ARREADY = !q.rvalid;
  assign S_AXI_RVALID  = q.rvalid;
  assign S_AXI_RDATA   = q.rdata;
  assign S_AXI_RRESP   = q.rresp;

endmodule

/* File: sim/freq_window_switch_assertions.sv */
// port-level assertions for the frequency window switch
`timescale 1ns/1ps
module freq_window_switch_assertions (
  input wire logic        CLK_SYS_I,
  input wire logic        ARST_N_I,
  input wire logic        BELOW_BAND_O,
  input wire logic        IN_BAND_O,
  input wire logic        ABOVE_BAND_O,
  input wire logic        SW_OUT1_O,
  input wire logic        SW_OUT2_O,
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0]  S_AXI_RRESP
);
  // ------------------------------------------------------------
  // single clock domain
  // ------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!ARST_N_I);

  // exclusivity must hold in either output polarity
  one_output_a: assert property (
    $onehot({BELOW_BAND_O, IN_BAND_O, ABOVE_BAND_O}) ||
    $onehot(~{BELOW_BAND_O, IN_BAND_O, ABOVE_BAND_O})) else $error("dual outputs clash");
  comp_out_a: assert property (
    SW_OUT2_O == !SW_OUT1_O) else $error("single outputs not complementary");
  // bus answers, timed as handed over
  write_lat_a: assert property (
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
    |=> !S_AXI_BVALID ##1 S_AXI_BVALID) else $error("write answer late");
  read_lat_a: assert property (
    S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID) else $error("read answer late");
  b_drop_a: assert property (
    S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID) else $error("bvalid stuck");
  r_drop_a: assert property (
    S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID) else $error("rvalid stuck");
  aw_refuse_a: assert property (
    S_AXI_AWVALID && S_AXI_AWREADY |=> !S_AXI_AWREADY) else $error("awready held");
  ar_refuse_a: assert property (
    S_AXI_RVALID |-> !S_AXI_ARREADY) else $error("arready during read");
  err_data_a: assert property (
    S_AXI_RVALID && S_AXI_RRESP == 2'h2 |-> S_AXI_RDATA == 32'h0) else $error("error data");
endmodule

bind freq_window_switch freq_window_switch_assertions chk (
  .CLK_SYS_I, .ARST_N_I, .BELOW_BAND_O, .IN_BAND_O, .ABOVE_BAND_O, .SW_OUT1_O,
  .SW_OUT2_O, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY,
  .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RVALID,
  .S_AXI_RREADY, .S_AXI_RDATA, .S_AXI_RRESP
);

/* File: sim/pickup_model.sv */
// pick-up source: shaped signal with a programmed period in clocks
`timescale 1ns/1ps
module pickup_model (
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic [15:0] period_i,
  output logic             sig_o
);
  int cnt_q;

  // period 0 is a dead sensor: the line rests, no crossings at all
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q <= 0;
      sig_o <= 1'b0;
    end else if (period_i == 16'h0) begin
      cnt_q <= 0;
    end else if (cnt_q >= int'(period_i) - 1) begin
      cnt_q <= 0;
      sig_o <= !sig_o; // one zero-crossing
    end else begin
      cnt_q <= cnt_q + 1;
    end
  end
endmodule

/* File: sim/freq_window_switch_tb_top.sv */
// self-checking bench for the frequency window switch
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
  total_checks++; \
  if ((g) !== (e)) begin \
    failures++; \
    $display("[FAIL] %s exp %0h got %0h", nm, e, g); \
  end \
end
module freq_window_switch_tb_top
  import freq_switch_pkg::*;
;
  // ------------------------------------------------------------
  // signals and instances
  // ------------------------------------------------------------
  localparam logic [15:0] slow_p = 16'h32;  // below band at 20/40
  localparam logic [15:0] mid_p  = 16'h1E;
  localparam logic [15:0] fast_p = 16'h10;
  localparam logic [2:0]  d_bl   = 3'h4;
  localparam logic [2:0]  d_in   = 3'h2;
  localparam logic [2:0]  d_ab   = 3'h1;
  logic        clk, rst_n, sig, below, inb, above, sw1, sw2;
  logic        awv, awr, wv, wr, bv, bready, arv, arr, rv, rready;
  logic [1:0]  bresp, rresp;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rd;
  logic [15:0] per;
  int          failures, total_checks;

  freq_window_switch uut (
    .CLK_SYS_I(clk), .ARST_N_I(rst_n), .SIG_I(sig), .BELOW_BAND_O(below),
    .IN_BAND_O(inb), .ABOVE_BAND_O(above), .SW_OUT1_O(sw1), .SW_OUT2_O(sw2),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_AWADDR(awa),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(bready), .S_AXI_BRESP(bresp),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ara),
    .S_AXI_RVALID(rv), .S_AXI_RREADY(rready), .S_AXI_RDATA(rd), .S_AXI_RRESP(rresp)
  );
  pickup_model pick (.clk_i(clk), .arst_n_i(rst_n), .period_i(per), .sig_o(sig));

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic final_report();
    if (failures == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask

  // address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (awr === 1'b1) awv <= 1'b0;
      if (wr === 1'b1) wv <= 1'b0;
      if (bv === 1'b1) break;
    end
    `CHK("bresp", er, bresp)
    bready <= 1'b0;
    if (n == 50) begin
      failures++;  // write never answered
      final_report();
    end
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (arr === 1'b1) arv <= 1'b0;
      if (rv === 1'b1) break;
    end
    `CHK("rdata", ed, rd)
    `CHK("rresp", er, rresp)
    rready <= 1'b0;
    if (n == 50) begin
      failures++;  // read never answered
      final_report();
    end
  endtask

  // set controls and input period, let eleven samples confirm, judge outputs
  task automatic settle(input logic [6:0] c, input logic [15:0] p,
                        input logic [2:0] e, input logic s);
    axi_wr(CTRL_OFS, {25'h0, c}, 2'h0);
    per <= p;
    wait_clk(14 * p + 20);
    `CHK("dual", e, {below, inb, above})
    `CHK("sw1", s, sw1)
    `CHK("sw2", !s, sw2)
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic sc_reset();
    wait_clk(2);
    `CHK("dual", 3'h3, {below, inb, above})
    `CHK("sw2", 1'b1, sw2)
    axi_rd(CTRL_OFS, {25'h0, CTRL_RESET}, 2'h0);
    axi_rd(UPPER_OFS, {8'h0, UPPER_RESET}, 2'h0);
    axi_rd(LOWER_OFS, {8'h0, LOWER_RESET}, 2'h0);
    axi_rd(FAIL_OFS, {8'h0, FAIL_RESET}, 2'h0);
    axi_rd(8'h18, 32'h0, 2'h2);
    axi_wr(STATUS_OFS, 32'h0, 2'h2);
    axi_wr(UPPER_OFS, 32'h14, 2'h0);
    axi_wr(LOWER_OFS, 32'h28, 2'h0);
    axi_wr(FAIL_OFS, 32'hC8, 2'h0);
    axi_rd(UPPER_OFS, 32'h14, 2'h0);
  endtask

  task automatic sc_dual();
    settle(7'h00, slow_p, d_bl, 1'b0);
    settle(7'h00, mid_p, d_in, 1'b0);
    // steady input: the last sample is exactly the programmed interval
    axi_rd(PERIOD_OFS, {16'h0, mid_p}, 2'h0);
    settle(7'h00, fast_p, d_ab, 1'b1);
    // confirmed above band, counter parked at its last step, no latches
    axi_rd(STATUS_OFS, {20'h0, 3'h0, CONFIRM_LAST, 5'h1E}, 2'h0);
    settle(7'h00, mid_p, d_in, 1'b0);
    settle(7'h00, slow_p, d_bl, 1'b0);
  endtask

  // too few samples must not switch; enough must
  task automatic sc_resp();
    settle(7'h00, mid_p, d_in, 1'b0);
    per <= fast_p;
    wait_clk(112);
    `CHK("early", d_in, {below, inb, above})
    wait_clk(132);
    `CHK("late", d_ab, {below, inb, above})
  endtask

  task automatic sc_noband();
    axi_wr(LOWER_OFS, 32'hA, 2'h0);
    settle(7'h00, mid_p, d_bl, 1'b0);
    settle(7'h00, fast_p, d_ab, 1'b1);
    axi_wr(LOWER_OFS, 32'h28, 2'h0);
    settle(7'h04, slow_p, 3'h3, 1'b0);
  endtask

  task automatic sc_latch();
    settle(7'h01, mid_p, d_in, 1'b0);
    settle(7'h01, fast_p, d_ab, 1'b1);
    settle(7'h01, mid_p, d_ab, 1'b0);
    settle(7'h00, mid_p, d_in, 1'b0);
    settle(7'h02, slow_p, d_bl, 1'b0);
    settle(7'h02, mid_p, d_bl, 1'b0);
    settle(7'h00, mid_p, d_in, 1'b0);
    settle(7'h03, fast_p, d_ab, 1'b1);
    settle(7'h03, mid_p, d_ab, 1'b0);
    settle(7'h00, mid_p, d_in, 1'b0);
    settle(7'h03, slow_p, d_bl, 1'b0);
    settle(7'h03, mid_p, d_bl, 1'b0);
    settle(7'h00, mid_p, d_in, 1'b0);
  endtask

  task automatic sc_single();
    settle(7'h20, mid_p, d_in, 1'b1);
    settle(7'h20, slow_p, d_bl, 1'b0);
    settle(7'h60, mid_p, d_in, 1'b0);
    settle(7'h60, fast_p, d_ab, 1'b1);
    settle(7'h60, mid_p, d_in, 1'b1);
    settle(7'h60, slow_p, d_bl, 1'b0);
    settle(7'h40, mid_p, d_in, 1'b0);
    settle(7'h40, fast_p, d_ab, 1'b1);
  endtask

  // low latch holds the output off until cleared with a high input
  task automatic sc_slatch();
    settle(7'h10, slow_p, d_bl, 1'b0);
    settle(7'h10, mid_p, d_in, 1'b0);
    settle(7'h10, fast_p, d_ab, 1'b0);
    settle(7'h00, fast_p, d_ab, 1'b1);
  endtask

  task automatic sc_fail();
    per <= 16'h0;
    wait_clk(400);
    `CHK("hold", d_ab, {below, inb, above})
    `CHK("hold_sw", 1'b1, sw1)
    axi_wr(CTRL_OFS, 32'h8, 2'h0);
    wait_clk(40);
    `CHK("forced", d_bl, {below, inb, above})
    `CHK("forced_sw", 1'b0, sw1)
  endtask

  // ------------------------------------------------------------
  // clock and main sequence
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = !clk;
  end

  initial begin
    {rst_n, awv, wv, bready, arv, rready} = '0;
    {awa, ara, wd, per} = '0;
    failures = 0;
    total_checks = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    sc_reset();
    sc_dual();
    sc_resp();
    sc_noband();
    sc_latch();
    sc_single();
    sc_slatch();
    sc_fail();
    final_report();
  end
endmodule
